// ### hw/sbc_regs_pkg.sv
// Package: register map, fields, reset values and timing constants
package sbc_regs_pkg;
    localparam logic [5:0] ADDR_SPECIAL = 6'h04;
    localparam logic [5:0] ADDR_TIMER_A = 6'h05;
    localparam logic [5:0] ADDR_ANALOG = 6'h06;
    localparam logic [5:0] ADDR_REFRESH = 6'h07;
    localparam logic [5:0] ADDR_IRQ_EN = 6'h08;
    localparam logic [5:0] ADDR_MODE = 6'h09;
    localparam logic [5:0] ADDR_RAIL = 6'h0A;
    localparam logic [7:0] RST_TIMER_A = 8'h1E;
    localparam logic [7:0] RST_TIMER_B = 8'hC0;
    localparam logic [7:0] RST_TIMER_C = 8'h00;
    localparam logic [7:0] RST_ANALOG = 8'h00;
    localparam logic [8:0] RST_IRQ_EN = 9'h000;
    localparam logic [7:0] RST_RAIL = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_RANDOM = 8'h5A;
    localparam logic [2:0] SEL_RESET = 3'h0;
    localparam logic [2:0] SEL_INIT = 3'h1;
    localparam logic [2:0] SEL_FLASH = 3'h2;
    localparam logic [2:0] SEL_SG_RESET = 3'h3;
    localparam int FRAME_BITS = 32;
    localparam logic [5:0] FRAME_LAST = 6'd31;
    localparam int WRITE_FLAG_BIT = 30;
    localparam int IRQ_HOST_REQ_BIT = 8;
    localparam logic [4:0] MODE_LP_OFF_MIN = 5'h0C;
    localparam logic [4:0] MODE_LP_OFF_MAX = 5'h0F;
    localparam int CLK_MHZ = 100;
    localparam int AUX_LONG_BLANK_US = 1000;
    localparam int SHORT_BLANK_US = 25;
    localparam logic [16:0] AUX_LONG_BLANK_CYC = 17'(AUX_LONG_BLANK_US * CLK_MHZ);
    localparam logic [16:0] SHORT_BLANK_CYC = 17'(SHORT_BLANK_US * CLK_MHZ);

    typedef enum logic [1:0] {DEV_NORMAL, DEV_INIT, DEV_FLASH, DEV_RESET} dev_mode_t;

    typedef struct packed {
        logic [2:0] host_current_sel;
        logic [4:0] normal_wdog_sel;
        logic [3:0] scan_period_sel;
        logic [3:0] cyclic_irq_sel;
        logic [3:0] lowpower_wdog_period_sel;
        logic [3:0] forced_wakeup_sel;
    } timer_cfg_t;

    typedef struct packed {
        logic lp_core_off;
        logic lp_core_on;
        logic forced_wakeup;
        logic periodic_sense;
        logic periodic_irq;
        logic lp_wdog;
    } lp_cfg_t;

    typedef struct packed {
        logic aux_on;
        logic aux_flags;
        logic can_on;
        logic can_flags;
    } rail_cfg_t;
endpackage : sbc_regs_pkg

// ### hw/sbc_timer_mode_config_regs.sv
// SPI register bank for timers, modes, interrupt enables and rail control
`timescale 1ns/1ps
module sbc_timer_mode_config_regs (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_spi_sck,
    input wire logic i_spi_cs_n,
    input wire logic i_spi_mosi,
    input wire logic [7:0] i_random_seed,
    input wire logic i_can_fault,
    input wire logic i_vmon_fault,
    input wire logic [3:0] i_lin_fault,
    input wire logic i_safe_fault,
    input wire logic i_aux_fault,
    input wire logic i_can_rail_fault,
    output logic o_spi_miso,
    output sbc_regs_pkg::dev_mode_t o_dev_mode,
    output sbc_regs_pkg::timer_cfg_t o_timer_cfg,
    output logic [4:0] o_analog_source_sel,
    output logic o_wdog_refresh,
    output logic o_irq,
    output sbc_regs_pkg::lp_cfg_t o_lp_cfg,
    output sbc_regs_pkg::rail_cfg_t o_rail_cfg,
    output logic o_aux_rail_en,
    output logic o_can_supply_rail_en,
    output logic o_aux_flag,
    output logic o_can_flag,
    output logic o_sg_regs_reset
);
    import sbc_regs_pkg::*;

    // Two-flop synchronisers for the SPI pins
    logic [1:0] sck_s_r, cs_s_r, mosi_s_r;
    logic sck_d_r;
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            sck_s_r <= 2'b00;
            cs_s_r <= 2'b11;
            mosi_s_r <= 2'b00;
            sck_d_r <= 1'b0;
        end else begin
            sck_s_r <= {sck_s_r[0], i_spi_sck};
            cs_s_r <= {cs_s_r[0], i_spi_cs_n};
            mosi_s_r <= {mosi_s_r[0], i_spi_mosi};
            sck_d_r <= sck_s_r[1];
        end
    end

    logic sck_rise, sck_fall, cs_act;
    assign sck_rise = sck_s_r[1] & ~sck_d_r;
    assign sck_fall = ~sck_s_r[1] & sck_d_r;
    assign cs_act = ~cs_s_r[1];

    // Frame shifter, MSB first, sampled on rising SCK
    logic [31:0] shift_r, miso_sh_r;
    logic [5:0] bit_cnt_r;
    logic frame_done_r;
    logic [31:0] frame_r;
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            shift_r <= 32'h0000_0000;
            bit_cnt_r <= 6'h00;
            frame_done_r <= 1'b0;
            frame_r <= 32'h0000_0000;
        end else begin
            frame_done_r <= 1'b0;
            if (!cs_act) begin
                bit_cnt_r <= 6'h00;
            end else if (sck_rise) begin
                shift_r <= {shift_r[30:0], mosi_s_r[1]};
                bit_cnt_r <= bit_cnt_r + 6'h01;
                if (bit_cnt_r == FRAME_LAST) begin
                    frame_r <= {shift_r[30:0], mosi_s_r[1]};
                    frame_done_r <= 1'b1;
                end
            end
        end
    end

    logic [5:0] addr;
    logic wr;
    logic [23:0] data;
    assign addr = frame_r[29:24];
    assign wr = frame_r[WRITE_FLAG_BIT];
    assign data = frame_r[23:0];

    // Free-running LFSR gives the random code; latched at each code read
    logic [7:0] lfsr_r, rnd_r, code_sent_r;
    logic seed_taken_r;
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            lfsr_r <= RST_RANDOM;
            seed_taken_r <= 1'b0;
        end else begin
            seed_taken_r <= 1'b1;
            if (!seed_taken_r && i_random_seed != 8'h00) begin
                lfsr_r <= i_random_seed;
            end else begin
                lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
            end
        end
    end

    // Registers
    logic [7:0] current_and_wdog_timer_r, scan_and_cyclic_timer_r, lowpower_wdog_wakeup_timer_r, analog_r, rail_r, mode_r;
    logic [8:0] irq_en_r;
    logic rnd_valid_r;
    dev_mode_t dev_mode_r;
    logic sg_reset_r, refresh_r;
    logic special_ok;
    logic [7:0] expect_code;
    logic [2:0] sel;
    assign sel = data[10:8];
    always_comb begin
        expect_code = ~rnd_r;
        if (sel == SEL_INIT) begin
            expect_code = {rnd_r[7:6], ~rnd_r[5:0]};
        end
    end
    // Flash keeps full inversion: bit layout wins over heading
    assign special_ok = rnd_valid_r && (data[7:0] == expect_code);

    // Timer B and C share the timer A address on bits 15:8 and 23:16
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            current_and_wdog_timer_r <= RST_TIMER_A;
            scan_and_cyclic_timer_r <= RST_TIMER_B;
            lowpower_wdog_wakeup_timer_r <= RST_TIMER_C;
            analog_r <= RST_ANALOG;
            irq_en_r <= RST_IRQ_EN;
            rail_r <= RST_RAIL;
            mode_r <= RST_MODE;
        end else if (frame_done_r && wr) begin
            unique case (addr)
                ADDR_TIMER_A: begin
                    current_and_wdog_timer_r <= data[7:0];
                    scan_and_cyclic_timer_r <= data[15:8];
                    lowpower_wdog_wakeup_timer_r <= data[23:16];
                end
                ADDR_ANALOG: analog_r <= {data[7:3], 3'b000};
                ADDR_IRQ_EN: irq_en_r <= data[8:0];
                ADDR_MODE: begin
                    // Core-off entry refused without permission
                    if (data[7:3] >= MODE_LP_OFF_MIN && data[7:3] <= MODE_LP_OFF_MAX
                        && !rail_r[0]) begin
                        mode_r <= mode_r;
                    end else begin
                        mode_r <= data[7:0];
                    end
                end
                ADDR_RAIL: rail_r <= {data[7:6], 1'b0, data[4:3], 2'b00, data[0]};
                default: ;
            endcase
        end
    end

    // Special mode and random code handling
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            rnd_r <= 8'h00;
            rnd_valid_r <= 1'b0;
            dev_mode_r <= DEV_NORMAL;
            sg_reset_r <= 1'b0;
        end else begin
            sg_reset_r <= 1'b0;
            if (frame_done_r && addr == ADDR_SPECIAL) begin
                if (!wr) begin
                    // Keep the code the host saw, not the running LFSR
                    rnd_r <= code_sent_r;
                    rnd_valid_r <= 1'b1;
                end else begin
                    rnd_valid_r <= 1'b0;
                    if (special_ok) begin
                        unique case (sel)
                            SEL_RESET: if (dev_mode_r == DEV_NORMAL) dev_mode_r <= DEV_RESET;
                            SEL_INIT: dev_mode_r <= DEV_INIT;
                            SEL_FLASH: if (dev_mode_r == DEV_NORMAL) dev_mode_r <= DEV_FLASH;
                            SEL_SG_RESET: sg_reset_r <= (dev_mode_r == DEV_NORMAL);
                            default: ;
                        endcase
                    end
                end
            end
        end
    end

    // MISO: code loaded into frame while CS is high, shifted on falling SCK
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            miso_sh_r <= 32'h0000_0000;
            code_sent_r <= 8'h00;
        end else if (!cs_act) begin
            miso_sh_r <= {24'h000000, lfsr_r};
            code_sent_r <= lfsr_r;
        end else if (sck_fall && bit_cnt_r != 6'h00) begin
            miso_sh_r <= {miso_sh_r[30:0], 1'b0};
        end
    end
    // Code bits 7:0 land at the frame's tail; write response is don't care
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_spi_miso <= 1'b0;
        end else begin
            o_spi_miso <= miso_sh_r[31];
        end
    end

    // Watchdog refresh and host-request pulses
    logic host_req_d_r;
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            refresh_r <= 1'b0;
            host_req_d_r <= 1'b0;
        end else begin
            refresh_r <= frame_done_r && wr && addr == ADDR_REFRESH
                && data == 24'h000000;
            host_req_d_r <= irq_en_r[IRQ_HOST_REQ_BIT];
        end
    end

    // Interrupt request: one-shot for host request, level-gated faults
    logic irq_nxt;
    always_comb begin
        irq_nxt = (irq_en_r[IRQ_HOST_REQ_BIT] & ~host_req_d_r);
        irq_nxt = irq_nxt | (|(irq_en_r[7:4] & i_lin_fault));
        irq_nxt = irq_nxt | (irq_en_r[3] & i_safe_fault);
        irq_nxt = irq_nxt | (irq_en_r[1] & i_can_fault);
        irq_nxt = irq_nxt | (irq_en_r[0] & i_vmon_fault);
    end

    // Rail blanking counters
    logic [16:0] aux_cnt_r, can_cnt_r;
    logic aux_en_r, can_en_r;
    logic aux_cut_r, can_cut_r;
    logic [16:0] aux_blank;
    assign aux_blank = (rail_r[7:6] == 2'b11) ? SHORT_BLANK_CYC : AUX_LONG_BLANK_CYC;
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            aux_cnt_r <= 17'h00000;
            aux_en_r <= 1'b0;
            aux_cut_r <= 1'b0;
        end else if (rail_r[7:6] == 2'b00) begin
            aux_cnt_r <= 17'h00000;
            aux_en_r <= 1'b0;
            aux_cut_r <= 1'b0;
        end else if (!i_aux_fault) begin
            aux_cnt_r <= 17'h00000;
            aux_en_r <= !aux_cut_r;
        end else if (aux_cnt_r >= aux_blank - 17'h00001) begin
            aux_en_r <= 1'b0;
            aux_cut_r <= 1'b1;
        end else begin
            aux_cnt_r <= aux_cnt_r + 17'h00001;
        end
    end
    // Once cut off, a rail stays off until its control field is set to off
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            can_cnt_r <= 17'h00000;
            can_en_r <= 1'b0;
            can_cut_r <= 1'b0;
        end else if (rail_r[4:3] == 2'b00) begin
            can_cnt_r <= 17'h00000;
            can_en_r <= 1'b0;
            can_cut_r <= 1'b0;
        end else if (!i_can_rail_fault || rail_r[4:3] != 2'b11) begin
            can_cnt_r <= 17'h00000;
            can_en_r <= !can_cut_r;
        end else if (can_cnt_r >= SHORT_BLANK_CYC - 17'h00001) begin
            can_en_r <= 1'b0;
            can_cut_r <= 1'b1;
        end else begin
            can_cnt_r <= can_cnt_r + 17'h00001;
        end
    end

    // Registered outputs
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_dev_mode <= DEV_NORMAL;
            o_timer_cfg <= '0;
            o_analog_source_sel <= 5'h00;
            o_wdog_refresh <= 1'b0;
            o_irq <= 1'b0;
            o_lp_cfg <= '0;
            o_rail_cfg <= '0;
            o_aux_rail_en <= 1'b0;
            o_can_supply_rail_en <= 1'b0;
            o_aux_flag <= 1'b0;
            o_can_flag <= 1'b0;
            o_sg_regs_reset <= 1'b0;
        end else begin
            o_dev_mode <= dev_mode_r;
            o_timer_cfg <= {current_and_wdog_timer_r[7:5], current_and_wdog_timer_r[4:0], scan_and_cyclic_timer_r[7:4], scan_and_cyclic_timer_r[3:0],
                lowpower_wdog_wakeup_timer_r[7:4], lowpower_wdog_wakeup_timer_r[3:0]};
            o_analog_source_sel <= analog_r[7:3];
            o_wdog_refresh <= refresh_r;
            o_irq <= irq_nxt;
            o_lp_cfg.lp_core_off <= mode_r[7:5] == 3'b011;
            o_lp_cfg.lp_core_on <= mode_r[7];
            o_lp_cfg.forced_wakeup <= mode_r[7] ? mode_r[6] : mode_r[4];
            o_lp_cfg.periodic_sense <= mode_r[7] ? mode_r[5] : mode_r[3];
            o_lp_cfg.periodic_irq <= mode_r[7] & mode_r[4];
            o_lp_cfg.lp_wdog <= mode_r[7] & mode_r[3];
            o_rail_cfg <= {rail_r[7:6] != 2'b00, rail_r[7], rail_r[4:3] != 2'b00, rail_r[4]};
            o_aux_rail_en <= aux_en_r;
            o_can_supply_rail_en <= can_en_r;
            o_aux_flag <= rail_r[7] & i_aux_fault;
            o_can_flag <= rail_r[4] & i_can_rail_fault;
            o_sg_regs_reset <= sg_reset_r;
        end
    end
endmodule : sbc_timer_mode_config_regs

// ### dv/sbc_spi_host.sv
// Host model: SPI master that issues 32-bit frames to the register bank
`timescale 1ns/1ps
module sbc_spi_host (
    input wire logic i_clk,
    input wire logic i_miso,
    output logic o_sck,
    output logic o_cs_n,
    output logic o_mosi
);
    // 8 clocks per half period gives the 160 ns link clock
    localparam int HALF = 8;

    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end

    task automatic gap(input int n);
        repeat (n) @(posedge i_clk);
    endtask : gap

    // Mode 0, MSB first, whole frames only; clock stands still between frames
    task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
        o_cs_n <= 1'b0;
        o_mosi <= tx[31];
        gap(HALF);
        for (int i = 31; i >= 0; i--) begin
            o_sck <= 1'b1;
            rx[i] = i_miso;
            gap(HALF);
            o_sck <= 1'b0;
            if (i > 0) begin
                o_mosi <= tx[i-1];
            end
            gap(HALF);
        end
        o_cs_n <= 1'b1;
        // Released line flips so a stale bit is never mistaken for data
        o_mosi <= ~o_mosi;
        gap(HALF);
    endtask : xfer
endmodule : sbc_spi_host

// ### dv/sbc_timer_mode_config_regs_properties.sv
// Port-level checks for the register bank, bound into the design
`timescale 1ns/1ps
module sbc_timer_mode_config_regs_properties (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_aux_fault,
    input wire logic i_can_rail_fault,
    input wire sbc_regs_pkg::dev_mode_t o_dev_mode,
    input wire sbc_regs_pkg::timer_cfg_t o_timer_cfg,
    input wire logic [4:0] o_analog_source_sel,
    input wire logic o_wdog_refresh,
    input wire logic o_irq,
    input wire sbc_regs_pkg::lp_cfg_t o_lp_cfg,
    input wire sbc_regs_pkg::rail_cfg_t o_rail_cfg,
    input wire logic o_aux_rail_en,
    input wire logic o_can_supply_rail_en,
    input wire logic o_sg_regs_reset
);
    import sbc_regs_pkg::*;
    logic [16:0] aux_run_r;
    logic [16:0] can_run_r;

    // Saturating fault run lengths; a cut-off is judged against them
    always_ff @(posedge i_clk) begin
        if (!i_reset_n || !i_aux_fault) begin
            aux_run_r <= 17'h00000;
        end else if (aux_run_r != 17'h1FFFF) begin
            aux_run_r <= aux_run_r + 17'h00001;
        end
    end
    always_ff @(posedge i_clk) begin
        if (!i_reset_n || !i_can_rail_fault) begin
            can_run_r <= 17'h00000;
        end else if (can_run_r != 17'h1FFFF) begin
            can_run_r <= can_run_r + 17'h00001;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    sequence s_aux_ctl_off;
        !o_rail_cfg.aux_on [*3];
    endsequence
    sequence s_can_ctl_off;
        !o_rail_cfg.can_on [*3];
    endsequence

    a_reset_defaults: assert property ($rose(i_reset_n) |=> o_timer_cfg == 24'h1EC000
        && !o_irq && o_analog_source_sel == 5'h00 && o_dev_mode == DEV_NORMAL)
        else $error("outputs not at reset values after reset release");
    a_refresh_single: assert property (o_wdog_refresh |=> !o_wdog_refresh)
        else $error("refresh pulse longer than one cycle");
    a_sg_reset_single: assert property (o_sg_regs_reset |=> !o_sg_regs_reset)
        else $error("switch-input reset pulse longer than one cycle");
    a_sg_from_normal: assert property (o_sg_regs_reset |-> o_dev_mode == DEV_NORMAL)
        else $error("switch-input reset outside normal mode");
    a_flash_from_normal: assert property ($changed(o_dev_mode) && o_dev_mode == DEV_FLASH
        |-> $past(o_dev_mode) == DEV_NORMAL)
        else $error("flash mode entered from a mode other than normal");
    a_lp_exclusive: assert property (!(o_lp_cfg.lp_core_off && o_lp_cfg.lp_core_on))
        else $error("both low-power kinds selected");
    a_core_off_feats: assert property (o_lp_cfg.lp_core_off
        |-> !o_lp_cfg.periodic_irq && !o_lp_cfg.lp_wdog)
        else $error("core-off mode with core-on features");
    a_aux_off_ctl: assert property (s_aux_ctl_off |-> !o_aux_rail_en)
        else $error("aux rail on while control is off");
    a_can_off_ctl: assert property (s_can_ctl_off |-> !o_can_supply_rail_en)
        else $error("can supply rail on while control is off");
    a_aux_blank_time: assert property ($fell(o_aux_rail_en) && o_rail_cfg.aux_on
        |-> aux_run_r >= 17'h00960)
        else $error("aux rail cut before blanking time");
    a_can_blank_time: assert property ($fell(o_can_supply_rail_en) && o_rail_cfg.can_on
        |-> can_run_r >= 17'h00960)
        else $error("can supply rail cut before blanking time");
endmodule : sbc_timer_mode_config_regs_properties

bind sbc_timer_mode_config_regs sbc_timer_mode_config_regs_properties chk (
    .i_clk, .i_reset_n, .i_aux_fault, .i_can_rail_fault, .o_dev_mode, .o_timer_cfg,
    .o_analog_source_sel, .o_wdog_refresh, .o_irq, .o_lp_cfg, .o_rail_cfg,
    .o_aux_rail_en, .o_can_supply_rail_en, .o_sg_regs_reset
);

// ### dv/tb.sv
// Self-checking bench for the timer, mode and rail register bank
`timescale 1ns/1ps
module tb;
    import sbc_regs_pkg::*;
    logic i_clk, i_reset_n, i_spi_sck, i_spi_cs_n, i_spi_mosi, o_spi_miso;
    logic i_can_fault, i_vmon_fault, i_safe_fault, i_aux_fault, i_can_rail_fault;
    logic [7:0] i_random_seed;
    logic [3:0] i_lin_fault;
    dev_mode_t o_dev_mode;
    timer_cfg_t o_timer_cfg;
    lp_cfg_t o_lp_cfg;
    rail_cfg_t o_rail_cfg;
    logic [4:0] o_analog_source_sel;
    logic o_wdog_refresh, o_irq, o_aux_rail_en, o_can_supply_rail_en, o_aux_flag, o_can_flag;
    logic o_sg_regs_reset;
    logic [31:0] rx;
    int error_cnt, samples_checked, cycles, refresh_cnt, irq_cnt, sg_cnt;
    logic [4:0] analog_mux_out [9] = '{5'h01, 5'h05, 5'h06, 5'h07, 5'h08, 5'h0B, 5'h12, 5'h13, 5'h00};

    sbc_timer_mode_config_regs uut (
        .i_clk, .i_reset_n, .i_spi_sck, .i_spi_cs_n, .i_spi_mosi, .i_random_seed,
        .i_can_fault, .i_vmon_fault, .i_lin_fault, .i_safe_fault, .i_aux_fault,
        .i_can_rail_fault, .o_spi_miso, .o_dev_mode, .o_timer_cfg, .o_analog_source_sel,
        .o_wdog_refresh, .o_irq, .o_lp_cfg, .o_rail_cfg, .o_aux_rail_en,
        .o_can_supply_rail_en, .o_aux_flag, .o_can_flag, .o_sg_regs_reset
    );
    sbc_spi_host host (
        .i_clk, .i_miso(o_spi_miso), .o_sck(i_spi_sck), .o_cs_n(i_spi_cs_n),
        .o_mosi(i_spi_mosi)
    );

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // Pulses are counted, since they stand for one cycle only
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        refresh_cnt <= refresh_cnt + int'(o_wdog_refresh === 1'b1);
        irq_cnt <= irq_cnt + int'(o_irq === 1'b1);
        sg_cnt <= sg_cnt + int'(o_sg_regs_reset === 1'b1);
        if (cycles == 30000) begin
            error_cnt++;
            test_done();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [5:0] addr, input logic [23:0] data);
        host.xfer({2'b01, addr, data}, rx);
        repeat (6) @(posedge i_clk);
    endtask : wr

    task automatic rd_code();
        host.xfer({2'b00, ADDR_SPECIAL, 24'h000000}, rx);
        repeat (6) @(posedge i_clk);
    endtask : rd_code

    task automatic test_done();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    initial begin
        i_reset_n = 1'b0;
        {i_can_fault, i_vmon_fault, i_safe_fault, i_aux_fault, i_can_rail_fault} = 5'h00;
        i_random_seed = 8'h00;
        i_lin_fault = 4'h0;
        repeat (10) @(posedge i_clk);
        i_reset_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        check("timer_cfg", o_timer_cfg, 24'h1EC000);
        check("analog", o_analog_source_sel, 5'h00);
        check("irq", o_irq, 1'b0);
        check("mode", o_dev_mode, DEV_NORMAL);
        // Wrong code byte first, then a fresh code used properly
        rd_code();
        wr(ADDR_SPECIAL, {13'h0, SEL_SG_RESET, ~rx[7:0] ^ 8'h01});
        check("sg_bad_code", sg_cnt, 32'h0);
        rd_code();
        wr(ADDR_SPECIAL, {13'h0, SEL_SG_RESET, ~rx[7:0]});
        check("sg_reset", sg_cnt, 32'h1);
        wr(ADDR_REFRESH, 24'h000000);
        check("refresh", refresh_cnt, 32'h1);
        wr(ADDR_REFRESH, 24'h000001);
        check("refresh_nz", refresh_cnt, 32'h1);
        wr(ADDR_TIMER_A, 24'hA53CE7);
        check("timer_wr", o_timer_cfg, 24'hE73CA5);
        foreach (analog_mux_out[k]) begin
            wr(ADDR_ANALOG, {16'h0000, analog_mux_out[k], 3'h0});
            check("analog_sel", o_analog_source_sel, analog_mux_out[k]);
        end
        wr(ADDR_IRQ_EN, 24'h000100);
        check("host_req", irq_cnt, 32'h1);
        i_can_fault <= 1'b1;
        wr(ADDR_IRQ_EN, 24'h000001);
        check("can_masked", o_irq, 1'b0);
        wr(ADDR_IRQ_EN, 24'h000002);
        check("can_irq", o_irq, 1'b1);
        i_can_fault <= 1'b0;
        i_vmon_fault <= 1'b1;
        wr(ADDR_IRQ_EN, 24'h000001);
        check("vmon_irq", o_irq, 1'b1);
        i_vmon_fault <= 1'b0;
        i_lin_fault <= 4'h4;
        wr(ADDR_IRQ_EN, 24'h000040);
        check("lin_irq", o_irq, 1'b1);
        i_lin_fault <= 4'h0;
        wr(ADDR_IRQ_EN, 24'h000000);
        wr(ADDR_MODE, 24'h000078);
        check("lp_refused", o_lp_cfg, 6'h00);
        wr(ADDR_RAIL, 24'h0000D9);
        check("rail_cfg", o_rail_cfg, 4'hF);
        i_aux_fault <= 1'b1;
        i_can_rail_fault <= 1'b1;
        repeat (2400) @(posedge i_clk);
        check("aux_blank", o_aux_rail_en, 1'b1);
        check("can_blank", o_can_supply_rail_en, 1'b1);
        repeat (200) @(posedge i_clk);
        check("aux_cut", o_aux_rail_en, 1'b0);
        check("can_cut", o_can_supply_rail_en, 1'b0);
        check("aux_flag", o_aux_flag, 1'b1);
        check("can_flag", o_can_flag, 1'b1);
        i_aux_fault <= 1'b0;
        i_can_rail_fault <= 1'b0;
        wr(ADDR_MODE, 24'h000078);
        check("lp_off", o_lp_cfg, 6'h2C);
        check("aux_latched", o_aux_rail_en, 1'b0);
        check("can_latched", o_can_supply_rail_en, 1'b0);
        check("aux_flag_clr", o_aux_flag, 1'b0);
        check("can_flag_clr", o_can_flag, 1'b0);
        wr(ADDR_MODE, 24'h0000A8);
        check("lp_on", o_lp_cfg, 6'h15);
        wr(ADDR_RAIL, 24'h000051);
        check("rail_mix", o_rail_cfg, 4'hB);
        wr(ADDR_RAIL, 24'h000000);
        check("rail_off", o_rail_cfg, 4'h0);
        check("aux_off", o_aux_rail_en, 1'b0);
        check("can_off", o_can_supply_rail_en, 1'b0);
        wr(ADDR_RAIL, 24'h000049);
        check("aux_back", o_aux_rail_en, 1'b1);
        check("can_back", o_can_supply_rail_en, 1'b1);
        // Flash last: later special writes other than init need normal mode
        rd_code();
        wr(ADDR_SPECIAL, {13'h0, SEL_FLASH, ~rx[7:0]});
        check("flash", o_dev_mode, DEV_FLASH);
        rd_code();
        wr(ADDR_SPECIAL, {13'h0, SEL_SG_RESET, ~rx[7:0]});
        check("sg_in_flash", sg_cnt, 32'h1);
        check("still_flash", o_dev_mode, DEV_FLASH);
        test_done();
    end
endmodule : tb
